// ===== mcu_interrupt_controller_test.sv
// Self-checking bench for the interrupt controller over APB.
// Assumes the core model answers stack commands and records PC loads.
`timescale 1ns/1ps
module mcu_interrupt_controller_test;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  mic_pkg::mic_evt_t  evt = '0;
  logic               pin0 = 1'b0;
  logic               pin1 = 1'b0;
  logic [1:0]         pull = 2'h0;
  logic [10:0]        pc_next;
  logic               push;
  logic               pop;
  logic               return_from_irq;
  mic_pkg::mic_pcld_t pc_load;
  logic               full;
  logic               wake;
  logic [1:0]         pull_en;
  int                 num_errors = 0;
  int                 compares = 0;
  int                 wakes = 0;
  int                 w0;

  always #20 clk = ~clk;

  mic_top dut (.SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_EVT(evt), .EXT_IRQ_PIN0(pin0),
    .EXT_IRQ_PIN1(pin1), .PULL_SEL(pull), .TIMER_LOW_SPEED_TICK(1'b0),
    .LOW_SPEED_TICK(1'b0), .PC_NEXT(pc_next), .CALL_PUSH(push), .RET_POP(pop),
    .RETURN_FROM_IRQ(return_from_irq), .PC_LOAD(pc_load), .STACK_FULL(full), .WAKE(wake),
    .EXT_PULL_EN(pull_en));

  mic_core_model core (.clk(clk), .pc_load(pc_load), .pc_next(pc_next),
    .call_push(push), .ret_pop(pop), .return_from_irq(return_from_irq));

  // Wake pulses are counted so a missing or doubled pulse shows
  always @(posedge clk) begin
    if (wake === 1'b1) begin
      wakes++;
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  // One APB transfer; waits for PREADY, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk_reg(q, exp);
    chk_reg({31'h0, e}, {31'h0, err});
  endtask : rd

  // Compares the oldest PC load, waiting a bounded time for it
  task automatic chk_load(input logic [10:0] exp);
    int          n;
    logic [10:0] a;
    n = 0;
    a = 11'h7FF;
    while (core.loads.size() == 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (core.loads.size() > 0) begin
      a = core.loads.pop_front();
    end
    chk_reg({21'h0, a}, {21'h0, exp});
  endtask : chk_load

  task automatic ev(input mic_pkg::mic_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask : ev

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Tests need about 1700 cycles; the limit leaves wide margin
  initial begin
    #(40 * 20000);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, access kinds and refusal
    rd(8'h08, 32'h00, 1'b0);
    rd(8'h0C, 32'h00, 1'b0);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'hFF, 1'b0);
    wr(8'h08, 32'h00);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h33, 1'b0);
    wr(8'h0C, 32'h00);
    rd(8'h40, 32'h00, 1'b1);
    $display("test registers done");
    // Latch without enable, wake, hold
    w0 = wakes;
    ev('{adc_done: 1'b1, default: 1'b0});
    repeat (3) @(posedge clk);
    chk_reg(wakes, w0 + 1);
    rd(8'h08, 32'h80, 1'b0);
    repeat (20) @(posedge clk);
    rd(8'h08, 32'h80, 1'b0);
    $display("test latch done");
    // Vector, auto clear, pending while masked, return
    wr(8'h08, 32'h88);
    wr(8'h04, 32'h01);
    chk_load(11'h01C);
    rd(8'h04, 32'h00, 1'b0);
    rd(8'h20, 32'h01, 1'b0);
    ev('{adc_done: 1'b1, default: 1'b0});
    rd(8'h08, 32'h88, 1'b0);
    chk_reg(core.loads.size(), 0);
    core.cmd(2, 11'h150);
    chk_load(11'h123);
    chk_load(11'h01C);
    core.cmd(1, 11'h150);
    chk_load(11'h150);
    $display("test vector done");
    // Priority of simultaneous requests
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h01);
    ev('{cmp_a: 1'b1, low_volt: 1'b1, default: 1'b0});
    wr(8'h04, 32'h01);
    chk_load(11'h010);
    rd(8'h08, 32'h01, 1'b0);
    rd(8'h0C, 32'h11, 1'b0);
    core.cmd(2, 11'h160);
    chk_load(11'h150);
    chk_load(11'h020);
    core.cmd(1, 11'h160);
    chk_load(11'h160);
    $display("test priority done");
    // Edge select codes on pin 0; its enable stays set so reads show it
    wr(8'h04, 32'h02);
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c));
      pin0 <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h04, {27'h0, c[0], 4'h2}, 1'b0);
      wr(8'h04, 32'h02);
      pin0 <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h04, {27'h0, c[1], 4'h2}, 1'b0);
      wr(8'h04, 32'h02);
    end
    wr(8'h00, 32'h01);
    wr(8'h04, 32'h03);
    pin0 <= 1'b1;
    chk_load(11'h004);
    rd(8'h04, 32'h02, 1'b0);
    core.cmd(1, 11'h160);
    chk_load(11'h160);
    $display("test pins done");
    // Full stack blocks acceptance until a pop
    for (int i = 0; i < 8; i++) begin
      core.cmd(0, 11'h200 + 11'(i));
    end
    rd(8'h20, 32'h18, 1'b0);
    chk_reg({31'h0, full}, 32'h1);
    wr(8'h0C, 32'h02);
    ev('{nvm_write: 1'b1, default: 1'b0});
    wr(8'h04, 32'h01);
    repeat (20) @(posedge clk);
    chk_reg(core.loads.size(), 0);
    core.cmd(1, 11'h170);
    chk_load(11'h207);
    chk_load(11'h024);
    $display("test stack done");
    // Tick 0 from system clock, shortest period of 256
    wr(8'h10, 32'h04);
    wr(8'h18, 32'h80);
    repeat (200) @(posedge clk);
    rd(8'h08, 32'h01, 1'b0);
    repeat (100) @(posedge clk);
    rd(8'h08, 32'h21, 1'b0);
    $display("test tick done");
    pull <= 2'h2;
    repeat (3) @(posedge clk);
    chk_reg({30'h0, pull_en}, 32'h2);
    $display("test pull done");
    // Pin 1 set for both edges, only the rising edge driven; latch only since its enable is clear
    wr(8'h00, 32'h0C);
    pin1 <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h04, 32'h20, 1'b0);
    $display("test pin1 done");
    // Tick 1 from system clock over four: 1024 cycles, phase within 4
    wr(8'h14, 32'h05);
    wr(8'h1C, 32'h80);
    repeat (990) @(posedge clk);
    rd(8'h08, 32'h21, 1'b0);
    repeat (40) @(posedge clk);
    rd(8'h08, 32'h61, 1'b0);
    $display("test tick1 done");
    summarize();
  end
endmodule : mcu_interrupt_controller_test

// ===== mic_core_model.sv
// Core model: drives PC_NEXT and stack commands, queues every PC load seen.
// Assumes the controller samples commands on the rising clock edge.
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic          clk,
  input  mic_pkg::mic_pcld_t pc_load,
  output logic [10:0]        pc_next,
  output logic               call_push,
  output logic               ret_pop,
  output logic               return_from_irq
);
  logic [10:0] loads[$];

  initial begin
    pc_next   = 11'h123;
    call_push = 1'b0;
    ret_pop   = 1'b0;
    return_from_irq      = 1'b0;
  end

  // Loads are queued, so two back-to-back loads are never lost
  always @(posedge clk) begin
    if (pc_load.valid === 1'b1) begin
      loads.push_back(pc_load.addr);
    end
  end

  // One-cycle command: 0 push, 1 return, 2 return with re-enable
  task automatic cmd(input int k, input logic [10:0] pc);
    @(posedge clk);
    pc_next   <= pc;
    call_push <= (k == 0);
    ret_pop   <= (k == 1);
    return_from_irq      <= (k == 2);
    @(posedge clk);
    call_push <= 1'b0;
    ret_pop   <= 1'b0;
    return_from_irq      <= 1'b0;
  endtask : cmd
endmodule : mic_core_model

// ===== mic_edge.sv
// Edge detector for one external interrupt pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
module mic_edge (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  output logic            hit
);
  logic prev_r;
  logic armed_r;

  // First sample only arms, so a pin already high at reset is no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= pin;
      armed_r <= 1'b1;
    end
  end

  // Selected transition gives a one-cycle hit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= armed_r & ((pin & ~prev_r & sel[mic_pkg::EDGE_RISE_BIT]) |
                        (~pin & prev_r & sel[mic_pkg::EDGE_FALL_BIT]));
    end
  end

  property p_edge_fall;
    @(posedge clk) disable iff (!rst_n)
      armed_r && !pin && prev_r && sel == 2'h2 |=> hit;
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");
endmodule : mic_edge

// ===== mic_pkg.sv
// Constants and carrier types for the interrupt controller block.
// Assumes a 32-bit APB slave port and 8-bit registers in the low byte lane.
package mic_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_EDGE   = 8'h00;
  localparam logic [7:0] OFF_CTL[3] = '{8'h04, 8'h08, 8'h0C};
  localparam logic [7:0] OFF_PSC[2] = '{8'h10, 8'h14};
  localparam logic [7:0] OFF_TB[2]  = '{8'h18, 8'h1C};
  localparam logic [7:0] OFF_STAT   = 8'h20;
  localparam logic [7:0] RST_REG    = 8'h00;

  // Sources in grant order, lowest index wins
  localparam int S_X0  = 0;
  localparam int S_X1  = 1;
  localparam int S_CMPP = 2;
  localparam int S_CMPA = 3;
  localparam int S_T0  = 4;
  localparam int S_T1  = 5;
  localparam int S_ADC = 6;
  localparam int S_LV  = 7;
  localparam int S_NVM = 8;
  localparam int NSRC  = 9;

  // Per source: control register number, latch bit, enable bit
  localparam int SRC_REG[NSRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2};
  localparam int SRC_RQB[NSRC] = '{4, 5, 6, 4, 5, 6, 7, 4, 5};
  localparam int SRC_ENB[NSRC] = '{1, 2, 3, 0, 1, 2, 3, 0, 1};
  localparam int B0_GIE        = 0;

  // Edge select field: bit 0 arms rising, bit 1 arms falling
  localparam int EDGE_FLD_W    = 2;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // Prescaler control and tick control fields
  localparam int         PSC_EN_BIT = 2;
  localparam int         TB_ON_BIT  = 7;
  localparam logic [1:0] CS_SYS     = 2'h0;
  localparam logic [1:0] CS_SYS4    = 2'h1;
  localparam logic [1:0] CS_LPTM    = 2'h2;
  localparam logic [1:0] DIV_SYS4   = 2'h3;
  localparam logic [2:0] DIV_L8     = 3'h7;
  localparam int         TB_MIN_EXP = 8;

  // Program counter, return stack and vectors
  localparam int          PC_W      = 11;
  localparam int          STK_DEPTH = 8;
  localparam int          SP_W      = 4;
  localparam logic [10:0] VEC_BASE  = 11'h004;
  localparam logic [10:0] VEC_STEP  = 11'h004;

  // Raw event strobes from the on-chip sources
  typedef struct packed {
    logic adc_done;
    logic cmp_a;
    logic cmp_p;
    logic nvm_write;
    logic low_volt;
  } mic_evt_t;

  // Program counter load toward the core
  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] addr;
  } mic_pcld_t;
endpackage : mic_pkg

// ===== mic_tick.sv
// Prescaler and periodic divider for one tick source.
// Assumes the two low-speed clocks arrive as one-cycle enables on clk.
`timescale 1ns/1ps
module mic_tick (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       psc_on,
  input  wire logic [1:0] src_sel,
  input  wire logic       tb_on,
  input  wire logic [2:0] period,
  input  wire logic       lptm_tick,
  input  wire logic       lirc_tick,
  output logic            ovf
);
  logic [1:0]  q4_r;
  logic [2:0]  q8_r;
  logic [14:0] div_r;
  logic [14:0] mask;
  logic        psc_tick;

  // Free-running pre-dividers for the divided sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q4_r <= 2'h0;
      q8_r <= 3'h0;
    end else begin
      q4_r <= q4_r + 2'h1;
      if (lirc_tick) begin
        q8_r <= q8_r + 3'h1;
      end
    end
  end

  // Source select; a disabled prescaler gives no ticks
  always_comb begin
    case (src_sel)
      mic_pkg::CS_SYS:  psc_tick = 1'b1;
      mic_pkg::CS_SYS4: psc_tick = (q4_r == mic_pkg::DIV_SYS4);
      mic_pkg::CS_LPTM: psc_tick = lptm_tick;
      default:          psc_tick = lirc_tick & (q8_r == mic_pkg::DIV_L8);
    endcase
    psc_tick = psc_tick & psc_on;
    mask = 15'((32'h1 << (mic_pkg::TB_MIN_EXP + 32'(period))) - 32'h1);
  end

  // Divider clears while off, so each enable starts a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 15'h0000;
      ovf   <= 1'b0;
    end else begin
      ovf <= tb_on & psc_tick & ((div_r & mask) == mask);
      if (!tb_on) begin
        div_r <= 15'h0000;
      end else if (psc_tick) begin
        div_r <= div_r + 15'h0001;
      end
    end
  end

  property p_tick_ovf;
    @(posedge clk) disable iff (!rst_n)
      ovf |-> $past(tb_on && psc_tick && div_r[7:0] == 8'hFF);
  endproperty
  a_tick_ovf: assert property (p_tick_ovf) else $error("overflow before period");
endmodule : mic_tick

// ===== mic_top.sv
// Vectored interrupt controller with return stack and APB registers.
// Assumes synchronous event strobes, a core that loads PC_LOAD when valid,
// and a core that reports CALL, RET and RETURN_FROM_IRQ one cycle each.
`timescale 1ns/1ps
module mic_top (
  input  wire logic               SYS_CLK,
  input  wire logic               RESETN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire mic_pkg::mic_evt_t  SRC_EVT,
  input  wire logic               EXT_IRQ_PIN0,
  input  wire logic               EXT_IRQ_PIN1,
  input  wire logic [1:0]         PULL_SEL,
  input  wire logic               TIMER_LOW_SPEED_TICK,
  input  wire logic               LOW_SPEED_TICK,
  input  wire logic [10:0]        PC_NEXT,
  input  wire logic               CALL_PUSH,
  input  wire logic               RET_POP,
  input  wire logic               RETURN_FROM_IRQ,
  output mic_pkg::mic_pcld_t      PC_LOAD,
  output logic                    STACK_FULL,
  output logic                    WAKE,
  output logic [1:0]              EXT_PULL_EN
);
  localparam int N = mic_pkg::NSRC;

  logic [3:0]                  edge_r;
  logic [2:0]                  psc_r [2];
  logic [3:0]                  tbc_r [2];
  logic                        gie_r;
  logic [N-1:0]                req_r;
  logic [N-1:0]                en_r;
  logic [N-1:0]                req_nxt;
  logic [N-1:0]                ev;
  logic [N-1:0]                pend;
  logic [N-1:0]                grant;
  logic [N-1:0]                sw_we;
  logic [N-1:0]                sw_val;
  logic [N-1:0]                en_val;
  logic [7:0]                  ctl_rd [3];
  logic [31:0]                 rd_mux;
  logic                        mapped;
  logic                        acc_c;
  logic                        wr_c;
  logic                        take_c;
  logic                        pop_c;
  logic                        push_c;
  logic [mic_pkg::PC_W-1:0]    vec_c;
  logic [mic_pkg::PC_W-1:0]    stk_r [mic_pkg::STK_DEPTH];
  logic [mic_pkg::SP_W-1:0]    sp_r;
  logic [mic_pkg::SP_W-1:0]    sp_nxt;
  logic [1:0]                  pins;
  logic [1:0]                  x_hit;
  logic [1:0]                  t_ovf;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : reg_hit

  function automatic logic [3:0] enc(input logic [N-1:0] oh);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (oh[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : enc

  // Pin edge detectors and tick generators, one pair per channel
  assign pins = {EXT_IRQ_PIN1, EXT_IRQ_PIN0};
  for (genvar k = 0; k < 2; k++) begin : g_chan
    mic_edge u_edge (
      .clk   (SYS_CLK),
      .rst_n (RESETN),
      .pin   (pins[k]),
      .sel   (edge_r[k*mic_pkg::EDGE_FLD_W +: mic_pkg::EDGE_FLD_W]),
      .hit   (x_hit[k])
    );
    mic_tick u_tick (
      .clk       (SYS_CLK),
      .rst_n     (RESETN),
      .psc_on    (psc_r[k][mic_pkg::PSC_EN_BIT]),
      .src_sel   (psc_r[k][1:0]),
      .tb_on     (tbc_r[k][3]),
      .period    (tbc_r[k][2:0]),
      .lptm_tick (TIMER_LOW_SPEED_TICK),
      .lirc_tick (LOW_SPEED_TICK),
      .ovf       (t_ovf[k])
    );
  end

  // Event vector in source order
  always_comb begin
    ev               = '0;
    ev[mic_pkg::S_X0]   = x_hit[0];
    ev[mic_pkg::S_X1]   = x_hit[1];
    ev[mic_pkg::S_CMPP] = SRC_EVT.cmp_p;
    ev[mic_pkg::S_CMPA] = SRC_EVT.cmp_a;
    ev[mic_pkg::S_T0]   = t_ovf[0];
    ev[mic_pkg::S_T1]   = t_ovf[1];
    ev[mic_pkg::S_ADC]  = SRC_EVT.adc_done;
    ev[mic_pkg::S_LV]   = SRC_EVT.low_volt;
    ev[mic_pkg::S_NVM]  = SRC_EVT.nvm_write;
  end

  // APB: one wait state, writes land at the edge that samples PREADY high
  assign acc_c = PSEL & PENABLE;
  assign wr_c  = acc_c & PWRITE & PREADY;

  // Software views of latches and enables; absent bits stay zero
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      ctl_rd[r] = mic_pkg::RST_REG;
    end
    ctl_rd[0][mic_pkg::B0_GIE] = gie_r;
    for (int i = 0; i < N; i++) begin
      ctl_rd[mic_pkg::SRC_REG[i]][mic_pkg::SRC_RQB[i]] = req_r[i];
      ctl_rd[mic_pkg::SRC_REG[i]][mic_pkg::SRC_ENB[i]] = en_r[i];
      sw_we[i]  = wr_c && reg_hit(PADDR, mic_pkg::OFF_CTL[mic_pkg::SRC_REG[i]]);
      sw_val[i] = PWDATA[mic_pkg::SRC_RQB[i]];
      en_val[i] = PWDATA[mic_pkg::SRC_ENB[i]];
    end
  end

  // Read mux and address decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b0;
    if (reg_hit(PADDR, mic_pkg::OFF_EDGE)) begin
      rd_mux = {28'h000_0000, edge_r};
      mapped = 1'b1;
    end
    if (reg_hit(PADDR, mic_pkg::OFF_STAT)) begin
      rd_mux = {27'h000_0000, STACK_FULL, sp_r};
      mapped = 1'b1;
    end
    for (int r = 0; r < 3; r++) begin
      if (reg_hit(PADDR, mic_pkg::OFF_CTL[r])) begin
        rd_mux = {24'h00_0000, ctl_rd[r]};
        mapped = 1'b1;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (reg_hit(PADDR, mic_pkg::OFF_PSC[k])) begin
        rd_mux = {29'h000_0000, psc_r[k]};
        mapped = 1'b1;
      end
      if (reg_hit(PADDR, mic_pkg::OFF_TB[k])) begin
        rd_mux = {24'h00_0000, tbc_r[k][3], 4'h0, tbc_r[k][2:0]};
        mapped = 1'b1;
      end
    end
  end

  // Bus answer flops; unmapped addresses answer with an error and zero data
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc_c & ~PREADY;
      PRDATA  <= (acc_c & ~PREADY & ~PWRITE) ? rd_mux : 32'h0000_0000;
      PSLVERR <= acc_c & ~PREADY & ~mapped;
    end
  end

  // Configuration registers for edges, prescalers and tick periods
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      edge_r <= 4'h0;
      for (int k = 0; k < 2; k++) begin
        psc_r[k] <= 3'h0;
        tbc_r[k] <= 4'h0;
      end
    end else begin
      if (wr_c && reg_hit(PADDR, mic_pkg::OFF_EDGE)) begin
        edge_r <= PWDATA[3:0];
      end
      for (int k = 0; k < 2; k++) begin
        if (wr_c && reg_hit(PADDR, mic_pkg::OFF_PSC[k])) begin
          psc_r[k] <= PWDATA[2:0];
        end
        if (wr_c && reg_hit(PADDR, mic_pkg::OFF_TB[k])) begin
          tbc_r[k] <= {PWDATA[mic_pkg::TB_ON_BIT], PWDATA[2:0]};
        end
      end
    end
  end

  // Grant: lowest pending index wins; core stack traffic defers acceptance
  assign pend   = req_r & en_r;
  assign grant  = pend & (~pend + {{(N-1){1'b0}}, 1'b1});
  assign take_c = (pend != '0) & gie_r & ~STACK_FULL & ~CALL_PUSH & ~RET_POP
                  & ~RETURN_FROM_IRQ;
  assign vec_c  = mic_pkg::VEC_BASE + mic_pkg::PC_W'(enc(grant)) * mic_pkg::VEC_STEP;
  assign pop_c  = (RET_POP | RETURN_FROM_IRQ) & (sp_r != '0);
  assign push_c = take_c | (CALL_PUSH & ~STACK_FULL);

  // Latch update: an event in the same cycle beats any clear
  assign req_nxt = (((req_r & ~sw_we) | (sw_val & sw_we)) & ~(take_c ? grant : '0)) | ev;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_r <= '0;
      en_r  <= '0;
    end else begin
      req_r <= req_nxt;
      for (int i = 0; i < N; i++) begin
        if (sw_we[i]) begin
          en_r[i] <= en_val[i];
        end
      end
    end
  end

  // Global enable: service clears it, return from interrupt with a non-empty stack sets it
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gie_r <= 1'b0;
    end else if (take_c) begin
      gie_r <= 1'b0;
    end else if (pop_c && RETURN_FROM_IRQ) begin
      gie_r <= 1'b1;
    end else if (wr_c && reg_hit(PADDR, mic_pkg::OFF_CTL[0])) begin
      gie_r <= PWDATA[mic_pkg::B0_GIE];
    end
  end

  // Return stack storage; holds data only, so it needs no reset
  always_ff @(posedge SYS_CLK) begin
    if (push_c) begin
      stk_r[sp_r[2:0]] <= PC_NEXT;
    end
  end

  // Stack pointer; a push wins over a pop in the same cycle
  always_comb begin
    sp_nxt = sp_r;
    if (push_c) begin
      sp_nxt = sp_r + 4'h1;
    end else if (pop_c) begin
      sp_nxt = sp_r - 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sp_r       <= 4'h0;
      STACK_FULL <= 1'b0;
    end else begin
      sp_r       <= sp_nxt;
      STACK_FULL <= (sp_nxt == mic_pkg::SP_W'(mic_pkg::STK_DEPTH));
    end
  end

  // Program counter load toward the core, one cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PC_LOAD <= '0;
    end else if (take_c) begin
      PC_LOAD <= '{valid: 1'b1, addr: vec_c};
    end else if (pop_c && !push_c) begin
      PC_LOAD <= '{valid: 1'b1, addr: stk_r[3'(sp_r - 4'h1)]};
    end else begin
      PC_LOAD <= '0;
    end
  end

  // Wake on any rising latch; pull-ups follow their selection unchanged
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WAKE        <= 1'b0;
      EXT_PULL_EN <= 2'h0;
    end else begin
      WAKE        <= |(req_nxt & ~req_r);
      EXT_PULL_EN <= PULL_SEL;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  property p_gie_clr;
    take_c |=> !gie_r;
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("global enable kept");

  property p_full_block;
    STACK_FULL |-> !take_c ##1 ($stable(sp_r) || $past(RET_POP || RETURN_FROM_IRQ));
  endproperty
  a_full_block: assert property (p_full_block) else $error("taken on full stack");

  property p_need_en;
    PC_LOAD.valid && $past(take_c) |-> $past(gie_r && (req_r & en_r) != '0);
  endproperty
  a_need_en: assert property (p_need_en) else $error("vector without enables");

  property p_vector;
    take_c |=> PC_LOAD.valid && PC_LOAD.addr == $past(vec_c) && sp_r == $past(sp_r) + 4'h1;
  endproperty
  a_vector: assert property (p_vector) else $error("vector or push wrong");

  property p_ev_set;
    ev != '0 |=> (req_r & $past(ev)) == $past(ev);
  endproperty
  a_ev_set: assert property (p_ev_set) else $error("event not latched");

  property p_wake;
    (req_r & ~$past(req_r)) != '0 |-> WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on rising latch");

  property p_return_from_irq;
    RETURN_FROM_IRQ && sp_r != '0 && !CALL_PUSH |=> gie_r && PC_LOAD.valid
      && PC_LOAD.addr == $past(stk_r[3'(sp_r - 4'h1)]);
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return did not restore");

  property p_hold;
    !wr_c && !take_c |=> (req_r & $past(req_r)) == $past(req_r);
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped");
endmodule : mic_top
